/* File: hw/inp_nvm_port.sv */
// Purpose: i2c target that writes, reads and erases config and eeprom memory
// Assumes: scl/sda and pins are asynchronous, sampled by 250 MHz mclk
// Notes:   open-drain sda; sda_oe_n low means the pin is pulled low
// Function
// RULE1: control code bits from config or pins
// RULE2: configured control code resets to 0001
// RULE3: three block-select bits follow control code
// RULE4: last control bit: one read, zero write
// RULE5: acknowledge a correctly received control byte
// RULE6: ack word address and sixteen page bytes
// RULE7: master ends page write with stop
// RULE8: stop starts programming, done within 20 ms
// RULE9: register space stays usable while programming
// RULE10: write control plus address loads counter
// RULE11: read control byte acked, then data driven
// RULE12: sequential bytes returned while master acks
// RULE13: master erases by writing register 0xe3
// RULE14: erase bit 4 picks nvm or eeprom
// RULE15: erase bits 3..0 give page number
// RULE16: erase field 110 starts, 000 disables
// RULE17: full flag erases whole array unless disabled
// RULE18: erase transfer acked, then master stops
// RULE19: stop after erase write runs erase cycle
// RULE20: register space stays usable while erasing
// RULE21: erase-enable bits self-clear when done
// RULE22: reads to 1 MHz, writes to 400 kHz
// RULE23: address is block select plus word byte
// RULE24: block codes 000, 010, 011 mapped, others unused
// RULE25: foreign control code gets no ack
// RULE26: page bytes advance address within page
`timescale 1ns/1ps
module inp_nvm_port #(
  parameter int unsigned PROG_CYCLES = inp_pkg::PROG_CYCLES
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe_n,
  input  wire logic control_code_pin_lsb,
  input  wire logic control_code_pin_b1,
  input  wire logic control_code_pin_b2,
  input  wire logic control_code_pin_msb,
  input  wire logic full_array_erase_flag,
  input  wire logic full_array_erase_disable,
  output logic      busy
);

  // pin synchroniser: two flops, then a third for edge history
  inp_pkg::inp_pins_t pins_raw, sync1_q, sync2_q, prev_q;
  logic scl_rise, scl_fall, start_c, stop_c;

  always_comb begin
    pins_raw.scl        = scl_i;
    pins_raw.sda        = sda_i;
    pins_raw.code_pin   = {control_code_pin_msb, control_code_pin_b2,
                           control_code_pin_b1, control_code_pin_lsb};
    pins_raw.full_erase = full_array_erase_flag;
    pins_raw.full_dis   = full_array_erase_disable;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync1_q <= inp_pkg::PINS_IDLE;
      sync2_q <= inp_pkg::PINS_IDLE;
      prev_q  <= inp_pkg::PINS_IDLE;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // 4 ns sampling resolves 1 MHz scl phases with wide margin
  always_comb begin
    scl_rise = sync2_q.scl && !prev_q.scl;  // RULE22
    scl_fall = !sync2_q.scl && prev_q.scl;
    start_c  = sync2_q.scl && prev_q.scl && prev_q.sda && !sync2_q.sda;
    stop_c   = sync2_q.scl && prev_q.scl && !prev_q.sda && sync2_q.sda;  // RULE7
  end

  // mapped blocks only; 001 and 1xx are unused
  function automatic logic blk_ok(input logic [2:0] b);
    blk_ok = (b == inp_pkg::BLK_REG) || (b == inp_pkg::BLK_NVM)
          || (b == inp_pkg::BLK_EEP);  // RULE24
  endfunction : blk_ok

  // memories: register space is volatile, the other two keep contents
  logic [7:0] reg_mem  [256];
  logic [7:0] nvm_mem  [256];
  logic [7:0] eep_mem  [256];
  logic [7:0] page_buf [16];

  // bus state
  inp_pkg::inp_bus_st_t bst_q, bst_d;
  logic [3:0] bitcnt_q, bitcnt_d;   // bits seen in current byte
  logic [7:0] shreg_q, shreg_d;     // rx/tx shift register
  logic [2:0] blk_q, blk_d;         // block select
  logic       rw_q, rw_d;           // direction bit
  logic [7:0] addr_q, addr_d;       // internal address counter
  logic       oe_n_q, oe_n_d;       // sda pull-down, low = pulling
  logic       mack_q, mack_d;       // master acked last read byte
  logic       dirty_q, dirty_d;     // page bytes taken since start
  logic       arm_q, arm_d;         // erase armed by register write
  logic       reg_we;
  logic       push_valid, push_ready;
  inp_pkg::inp_wr_word_t push_word;

  // engine state
  inp_pkg::inp_eng_st_t eng_q, eng_d;
  logic [inp_pkg::TIMER_W-1:0] timer_q, timer_d;
  logic [7:0]  er_q, er_d;          // erase command snapshot
  logic        pg_eep_q, pg_eep_d;
  logic [3:0]  pg_page_q, pg_page_d;
  logic [15:0] pg_mask_q, pg_mask_d;
  logic        commit, erase_done, timer_end, eng_busy;
  logic        pop_valid, pop_ready;
  logic [16:0] pop_data;
  inp_pkg::inp_wr_word_t pop_word;

  // derived decode
  logic [3:0] my_code, code_src;
  logic       rx_state, rx_done, ctrl_ok, code_ok;
  logic [7:0] rd_byte;

  always_comb begin
    code_src  = reg_mem[inp_pkg::CTRL_CODE_BYTE][inp_pkg::CTRL_SRC_LSB +: 4];
    // each bit picks pin or config bit on its own
    for (int i = 0; i < 4; i++) begin
      my_code[i] = code_src[i] ? sync2_q.code_pin[i]
                               : reg_mem[inp_pkg::CTRL_CODE_BYTE][i];  // RULE1
    end
    rx_state  = (bst_q == inp_pkg::BS_CTRL) || (bst_q == inp_pkg::BS_WADDR)
             || (bst_q == inp_pkg::BS_WDATA);
    rx_done   = scl_fall && (bitcnt_q == 4'h8);
    code_ok   = (shreg_q[7:4] == my_code);  // RULE25
    // memory blocks refuse new access while a cycle runs
    ctrl_ok   = code_ok && blk_ok(shreg_q[3:1])
             && ((shreg_q[3:1] == inp_pkg::BLK_REG) || !eng_busy);  // RULE9 RULE20
    case (blk_q)
      inp_pkg::BLK_NVM: rd_byte = nvm_mem[addr_q];
      inp_pkg::BLK_EEP: rd_byte = eep_mem[addr_q];
      default:          rd_byte = reg_mem[addr_q];
    endcase
    push_word.eep  = (blk_q == inp_pkg::BLK_EEP);
    push_word.addr = addr_q;
    push_word.data = shreg_q;
  end

  // bus protocol next state
  always_comb begin
    bst_d = bst_q;  bitcnt_d = bitcnt_q;  shreg_d = shreg_q;
    blk_d = blk_q;  rw_d = rw_q;  addr_d = addr_q;  oe_n_d = oe_n_q;
    mack_d = mack_q;  dirty_d = dirty_q;  arm_d = arm_q;
    reg_we = 1'b0;
    push_valid = 1'b0;
    if (rx_state && scl_rise) begin
      shreg_d  = {shreg_q[6:0], sync2_q.sda};
      bitcnt_d = bitcnt_q + 4'h1;
    end
    if (stop_c) begin
      // stop hands a page, else an erase, to the engine only while it is idle
      bst_d   = inp_pkg::BS_IDLE;
      oe_n_d  = 1'b1;
      dirty_d = 1'b0;
      arm_d   = 1'b0;
    end else if (start_c) begin
      // repeated start drops write decoding, keeps addr_q
      bst_d    = inp_pkg::BS_CTRL;  // RULE10
      bitcnt_d = 4'h0;
      oe_n_d   = 1'b1;
    end else begin
      case (bst_q)
        inp_pkg::BS_CTRL: begin
          if (rx_done) begin
            bitcnt_d = 4'h0;
            blk_d    = shreg_q[3:1];  // RULE3 RULE23
            rw_d     = shreg_q[0];    // RULE4
            if (ctrl_ok) begin
              oe_n_d = 1'b0;  // RULE5
              bst_d  = inp_pkg::BS_ACK_CTRL;
            end else begin
              bst_d  = inp_pkg::BS_IGNORE;  // RULE25
            end
          end
        end
        inp_pkg::BS_ACK_CTRL: begin
          if (scl_fall) begin
            bitcnt_d = 4'h0;
            if (rw_q) begin
              shreg_d = rd_byte;  // RULE11
              oe_n_d  = rd_byte[7];
              bst_d   = inp_pkg::BS_RDATA;
            end else begin
              oe_n_d  = 1'b1;
              bst_d   = inp_pkg::BS_WADDR;
            end
          end
        end
        inp_pkg::BS_WADDR: begin
          if (rx_done) begin
            bitcnt_d = 4'h0;
            addr_d   = shreg_q;  // RULE10 RULE23
            oe_n_d   = 1'b0;     // RULE6
            bst_d    = inp_pkg::BS_ACK_WADDR;
          end
        end
        inp_pkg::BS_ACK_WADDR, inp_pkg::BS_ACK_WDATA: begin
          if (scl_fall) begin
            oe_n_d = 1'b1;
            bst_d  = inp_pkg::BS_WDATA;
          end
        end
        inp_pkg::BS_WDATA: begin
          if (rx_done) begin
            bitcnt_d = 4'h0;
            if (blk_q == inp_pkg::BLK_REG) begin
              reg_we = 1'b1;
              addr_d = addr_q + 8'h01;
              oe_n_d = 1'b0;  // RULE18
              bst_d  = inp_pkg::BS_ACK_WDATA;
              if (addr_q == inp_pkg::ERASE_REG
                  && shreg_q[7:5] == inp_pkg::ERASE_EN_GO) begin
                arm_d = 1'b1;  // RULE16
              end
            end else begin
              push_valid = 1'b1;
              if (push_ready) begin
                addr_d  = {addr_q[7:4], addr_q[3:0] + 4'h1};  // RULE26
                dirty_d = 1'b1;
                oe_n_d  = 1'b0;  // RULE6
                bst_d   = inp_pkg::BS_ACK_WDATA;
              end else begin
                bst_d   = inp_pkg::BS_IGNORE;
              end
            end
          end
        end
        inp_pkg::BS_RDATA: begin
          if (scl_fall) begin
            if (bitcnt_q == 4'h8) begin
              oe_n_d   = 1'b1;  // release for master ack
              bitcnt_d = 4'h0;
              addr_d   = addr_q + 8'h01;  // RULE12
              bst_d    = inp_pkg::BS_RACK;
            end else begin
              shreg_d  = {shreg_q[6:0], 1'b0};
              oe_n_d   = shreg_q[6];
            end
          end else if (scl_rise) begin
            bitcnt_d = bitcnt_q + 4'h1;
          end
        end
        inp_pkg::BS_RACK: begin
          if (scl_rise) begin
            mack_d = !sync2_q.sda;
          end else if (scl_fall) begin
            if (mack_q) begin
              shreg_d = rd_byte;  // RULE12
              oe_n_d  = rd_byte[7];
              bst_d   = inp_pkg::BS_RDATA;
            end else begin
              bst_d   = inp_pkg::BS_IGNORE;
            end
          end
        end
        inp_pkg::BS_IDLE, inp_pkg::BS_IGNORE: begin
          oe_n_d = 1'b1;
        end
        default: begin
          bst_d  = inp_pkg::BS_IDLE;
          oe_n_d = 1'b1;
        end
      endcase
    end
  end

  // bus registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bst_q <= inp_pkg::BS_IDLE;  bitcnt_q <= '0;  shreg_q <= '0;
      blk_q <= '0;  rw_q <= 1'b0;  addr_q <= '0;  oe_n_q <= 1'b1;
      mack_q <= 1'b0;  dirty_q <= 1'b0;  arm_q <= 1'b0;
    end else begin
      bst_q <= bst_d;  bitcnt_q <= bitcnt_d;  shreg_q <= shreg_d;
      blk_q <= blk_d;  rw_q <= rw_d;  addr_q <= addr_d;  oe_n_q <= oe_n_d;
      mack_q <= mack_d;  dirty_q <= dirty_d;  arm_q <= arm_d;
    end
  end

  // page-write bytes queue here; the engine stalls the drain while timing
  inp_fifo #(
    .WIDTH ($bits(inp_pkg::inp_wr_word_t)),
    .DEPTH (inp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_word),
    .out_valid (pop_valid),
    .out_ready (pop_ready),
    .out_data  (pop_data)
  );

  // self-timed engine next state
  always_comb begin
    eng_d = eng_q;  timer_d = timer_q;  er_d = er_q;
    pg_eep_d = pg_eep_q;  pg_page_d = pg_page_q;  pg_mask_d = pg_mask_q;
    pop_word  = inp_pkg::inp_wr_word_t'(pop_data);
    pop_ready = (eng_q == inp_pkg::ES_IDLE) || (eng_q == inp_pkg::ES_DRAIN);
    timer_end = (timer_q == inp_pkg::TIMER_W'(PROG_CYCLES - 1));
    commit     = (eng_q == inp_pkg::ES_PROG) && timer_end;
    erase_done = (eng_q == inp_pkg::ES_ERASE) && timer_end;
    eng_busy   = (eng_q != inp_pkg::ES_IDLE) || dirty_q;
    if (pop_valid && pop_ready) begin
      pg_eep_d  = pop_word.eep;
      pg_page_d = pop_word.addr[7:4];
      pg_mask_d = pg_mask_q | (16'h0001 << pop_word.addr[3:0]);
    end
    case (eng_q)
      inp_pkg::ES_IDLE: begin
        timer_d = '0;
        // a page write wins over an erase armed in the same transfer
        if (stop_c && dirty_q) begin
          eng_d = inp_pkg::ES_DRAIN;  // RULE8
        end else if (stop_c && arm_q) begin
          er_d  = reg_mem[inp_pkg::ERASE_REG];
          eng_d = inp_pkg::ES_ERASE;  // RULE19
        end
      end
      inp_pkg::ES_DRAIN: begin
        if (!pop_valid) begin
          eng_d = inp_pkg::ES_PROG;
        end
      end
      inp_pkg::ES_PROG, inp_pkg::ES_ERASE: begin
        timer_d = timer_q + 1'b1;  // RULE8 RULE19
        if (timer_end) begin
          eng_d     = inp_pkg::ES_IDLE;
          pg_mask_d = '0;
        end
      end
      default: eng_d = inp_pkg::ES_IDLE;
    endcase
  end

  // engine registers and outputs
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      eng_q <= inp_pkg::ES_IDLE;  timer_q <= '0;  er_q <= '0;
      pg_eep_q <= 1'b0;  pg_page_q <= '0;  pg_mask_q <= '0;
      sda_oe_n <= 1'b1;  sda_o <= 1'b0;  busy <= 1'b0;
    end else begin
      eng_q <= eng_d;  timer_q <= timer_d;  er_q <= er_d;
      pg_eep_q <= pg_eep_d;  pg_page_q <= pg_page_d;  pg_mask_q <= pg_mask_d;
      sda_oe_n <= oe_n_d;  sda_o <= 1'b0;
      busy <= (eng_d != inp_pkg::ES_IDLE) || dirty_d;
    end
  end

  // register space: write from bus, erase field self-clears afterwards
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 256; i++) begin
        reg_mem[i] <= (i == int'(inp_pkg::CTRL_CODE_BYTE)) ? inp_pkg::CTRL_CODE_RESET
                                                           : 8'h00;  // RULE2
      end
    end else begin
      if (reg_we) begin
        reg_mem[addr_q] <= shreg_q;
      end
      if (erase_done) begin
        reg_mem[inp_pkg::ERASE_REG][7:5] <= inp_pkg::ERASE_EN_OFF;  // RULE21
      end
    end
  end

  // page buffer and nonvolatile arrays, no reset: contents persist
  always_ff @(posedge mclk) begin
    if (pop_valid && pop_ready) begin
      page_buf[pop_word.addr[3:0]] <= pop_word.data;
    end
    for (int i = 0; i < 16; i++) begin
      if (commit && pg_mask_q[i] && !pg_eep_q) nvm_mem[{pg_page_q, 4'(i)}] <= page_buf[i];
      if (commit && pg_mask_q[i] && pg_eep_q)  eep_mem[{pg_page_q, 4'(i)}] <= page_buf[i];
    end
    if (erase_done && sync2_q.full_erase && !sync2_q.full_dis) begin
      for (int i = 0; i < 256; i++) begin
        nvm_mem[i] <= inp_pkg::ERASED_BYTE;  // RULE17
        eep_mem[i] <= inp_pkg::ERASED_BYTE;
      end
    end else if (erase_done && !sync2_q.full_erase) begin
      for (int i = 0; i < 16; i++) begin
        if (er_q[inp_pkg::ERASE_TGT_BIT])  // RULE14
          eep_mem[{er_q[3:0], 4'(i)}] <= inp_pkg::ERASED_BYTE;  // RULE15
        else
          nvm_mem[{er_q[3:0], 4'(i)}] <= inp_pkg::ERASED_BYTE;
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  ack_ctrl_a: assert property (bst_q == inp_pkg::BS_ACK_CTRL |-> !sda_oe_n) // RULE5
    else $error("control byte not acked");
  code_miss_a: assert property (bst_q == inp_pkg::BS_CTRL && rx_done && !code_ok // RULE25
    |=> (bst_q == inp_pkg::BS_IGNORE && sda_oe_n) [*2])
    else $error("foreign control code handled");
  reg_access_a: assert property (bst_q == inp_pkg::BS_CTRL && rx_done && code_ok // RULE9
    && shreg_q[3:1] == inp_pkg::BLK_REG |=> bst_q == inp_pkg::BS_ACK_CTRL)
    else $error("register space refused");
  read_dir_a: assert property (bst_q == inp_pkg::BS_ACK_CTRL && scl_fall && rw_q // RULE4
    && !stop_c && !start_c |=> bst_q == inp_pkg::BS_RDATA)
    else $error("read direction not honoured");
  page_wrap_a: assert property (bst_q == inp_pkg::BS_WDATA && push_valid && push_ready // RULE26
    |=> addr_q[7:4] == $past(addr_q[7:4]) && addr_q[3:0] == $past(addr_q[3:0]) + 4'h1)
    else $error("page address step wrong");
  prog_start_a: assert property (stop_c && dirty_q && eng_q == inp_pkg::ES_IDLE // RULE8
    |=> eng_q == inp_pkg::ES_DRAIN ##[1:9] eng_q == inp_pkg::ES_PROG)
    else $error("programming did not start");
  // bound against the 20 ms figure, so an oversized parameter is caught too
  prog_bound_a: assert property (eng_q inside {inp_pkg::ES_PROG, inp_pkg::ES_ERASE} // RULE19
    |-> timer_q < inp_pkg::TIMER_W'(inp_pkg::PROG_CYCLES))
    else $error("self-timed cycle too long");
  erase_clear_a: assert property (erase_done // RULE21
    |=> reg_mem[inp_pkg::ERASE_REG][7:5] == inp_pkg::ERASE_EN_OFF)
    else $error("erase enable not cleared");
  erase_arm_a: assert property (reg_we && addr_q == inp_pkg::ERASE_REG // RULE16
    && shreg_q[7:5] == inp_pkg::ERASE_EN_GO && !stop_c |=> arm_q)
    else $error("erase not armed");

endmodule : inp_nvm_port

/* File: hw/inp_pkg.sv */
// Purpose: shared constants and types for the i2c nvm program port
// Assumes: 250 MHz mclk, scl/sda sampled as plain inputs
// Notes:   byte offsets are word addresses inside the register space
package inp_pkg;

  // block select codes (top three address bits)
  localparam logic [2:0] BLK_REG = 3'h0;  // register configuration space
  localparam logic [2:0] BLK_NVM = 3'h2;  // nonvolatile_config_space
  localparam logic [2:0] BLK_EEP = 3'h3;  // emulated eeprom space

  // control code byte: code bits [3:0], source selects [7:4]
  localparam logic [7:0] CTRL_CODE_BYTE  = 8'h7f;
  localparam logic [7:0] CTRL_CODE_RESET = 8'h01;  // code 0001, all from config bits
  localparam int         CTRL_SRC_LSB    = 4;

  // page_erase_control register and its fields
  localparam logic [7:0] ERASE_REG      = 8'he3;
  localparam int         ERASE_EN_LSB   = 5;  // erase_enable_field [7:5]
  localparam int         ERASE_TGT_BIT  = 4;  // erase_target_select
  localparam logic [2:0] ERASE_EN_GO    = 3'h6;
  localparam logic [2:0] ERASE_EN_OFF   = 3'h0;
  localparam logic [7:0] ERASED_BYTE    = 8'hff;

  // self-timed cycle: 20 ms longest time, rounded down to clocks
  localparam int unsigned PROG_TIME_NS  = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned PROG_CYCLES   = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int          TIMER_W       = 23;

  localparam int FIFO_DEPTH = 8;

  // one page-write byte on its way to the page buffer
  typedef struct packed {
    logic       eep;
    logic [7:0] addr;
    logic [7:0] data;
  } inp_wr_word_t;

  // pins crossing into mclk
  typedef struct packed {
    logic       scl;
    logic       sda;
    logic [3:0] code_pin;
    logic       full_erase;
    logic       full_dis;
  } inp_pins_t;

  // idle bus levels for the synchroniser, so reset leaves no false scl edge
  localparam inp_pins_t PINS_IDLE = '{scl: 1'b1, sda: 1'b1, code_pin: 4'h0,
                                       full_erase: 1'b0, full_dis: 1'b0};

  typedef enum logic [9:0] {
    BS_IDLE      = 10'h001,
    BS_CTRL      = 10'h002,
    BS_ACK_CTRL  = 10'h004,
    BS_WADDR     = 10'h008,
    BS_ACK_WADDR = 10'h010,
    BS_WDATA     = 10'h020,
    BS_ACK_WDATA = 10'h040,
    BS_RDATA     = 10'h080,
    BS_RACK      = 10'h100,
    BS_IGNORE    = 10'h200
  } inp_bus_st_t;

  typedef enum logic [3:0] {
    ES_IDLE  = 4'h1,
    ES_DRAIN = 4'h2,
    ES_PROG  = 4'h4,
    ES_ERASE = 4'h8
  } inp_eng_st_t;

endpackage : inp_pkg

/* File: hw/inp_fifo.sv */
// Purpose: small valid/ready fifo for page-write bytes
// Assumes: same clock on both sides, DEPTH a power of two
// Notes:   push and pop may happen in the same cycle
`timescale 1ns/1ps
module inp_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];  // entries
  logic [AW:0]      wr_q, wr_d;     // write pointer, extra wrap bit
  logic [AW:0]      rd_q, rd_d;     // read pointer
  logic             push, pop;

  // full when pointers differ only in the wrap bit
  always_comb begin
    in_ready  = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
    out_valid = (wr_q != rd_q);
    out_data  = store[rd_q[AW-1:0]];
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    wr_d      = push ? wr_q + 1'b1 : wr_q;
    rd_d      = pop ? rd_q + 1'b1 : rd_q;
  end

  // pointers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  // storage, no reset needed: empty entries are never read
  always_ff @(posedge mclk) begin
    if (push) begin
      store[wr_q[AW-1:0]] <= in_data;
    end
  end

endmodule : inp_fifo

/* File: tb/inp_i2c_master.sv */
// Purpose: i2c bus master model for the program port
// Assumes: bench resolves sda with a pull-up
// Notes:   scl period 125 ns, scl stands high between frames
`timescale 1ns/1ps
module inp_i2c_master (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  localparam realtime Q = 31.25; // quarter scl period
  // idle bus: both lines released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // data set while scl low, sampled mid high
  task automatic bit_io(input logic b, output logic r);
    sda_low = ~b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
    #Q;
  endtask : bit_io
  // start, or repeated start from scl low
  task automatic start();
    sda_low = 1'b0;
    #Q scl = 1'b1;
    #Q sda_low = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask : start
  // every transfer ends here
  task automatic stop();
    sda_low = 1'b1;
    #Q scl = 1'b1;
    #Q sda_low = 1'b0;
    #(2 * Q);
  endtask : stop
  // byte out msb first, returns the device ack
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : wbyte
  // byte in, then ack to go on or nack to finish
  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(~mack, r);
  endtask : rbyte
endmodule : inp_i2c_master

/* File: tb/i2c_nvm_program_port_tb_top.sv */
// Purpose: self-checking bench for the program port
// Assumes: short programming time through PROG_CYCLES
// Notes:   the internal fifo is exercised through page writes of the port
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module i2c_nvm_program_port_tb_top;
  localparam int PROG = 4000; // long enough to overlap register traffic
  localparam int WAIT = 6000;
  logic mclk, rst, scl, sda_low, busy, sda_o, sda_oe_n, fl, fd;
  logic [3:0] pins, code;
  logic [7:0] seed, ev, q[$], r[$];
  int compares, failures;
  wire sda = ~(sda_low | ~sda_oe_n); // pull-up, wired-and
  inp_nvm_port #(.PROG_CYCLES(PROG)) i_dut (.mclk(mclk), .rst(rst), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .control_code_pin_lsb(pins[0]),
    .control_code_pin_b1(pins[1]), .control_code_pin_b2(pins[2]),
    .control_code_pin_msb(pins[3]), .full_array_erase_flag(fl),
    .full_array_erase_disable(fd), .busy(busy));
  inp_i2c_master i_mst (.scl(scl), .sda_low(sda_low), .sda(sda));
  // random bytes, seed fixed
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  // control byte after a start
  task automatic ctrl(input logic [3:0] c, input logic [2:0] b, input logic rw,
                      input logic ea);
    logic a;
    i_mst.start();
    i_mst.wbyte({c, b, rw}, a);
    `CHK("ctrl ack", ea, a)
  endtask : ctrl
  // control, word address, data bytes, stop
  task automatic wr(input logic [2:0] b, input logic [7:0] ad, input logic [7:0] d[$]);
    logic a;
    ctrl(code, b, 1'b0, 1'b1);
    i_mst.wbyte(ad, a);
    `CHK("addr ack", 1'b1, a)
    foreach (d[i]) begin
      i_mst.wbyte(d[i], a);
      `CHK("data ack", 1'b1, a)
    end
    i_mst.stop();
  endtask : wr
  // random sequential read of n bytes into r
  task automatic rd(input logic [2:0] b, input logic [7:0] ad, input int n);
    logic a;
    logic [7:0] v;
    r = {};
    ctrl(code, b, 1'b0, 1'b1);
    i_mst.wbyte(ad, a);
    ctrl(code, b, 1'b1, 1'b1);
    for (int i = 0; i < n; i++) begin
      i_mst.rbyte(i < n - 1, v);
      r.push_back(v);
    end
    i_mst.stop();
  endtask : rd
  // bounded wait for the self-timed cycle
  task automatic wait_idle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < WAIT) begin
      @(posedge mclk);
      k++;
    end
    `CHK("busy done", 1'b0, busy)
  endtask : wait_idle
  task automatic report_and_stop();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // hang guard, well above the roughly 60k cycles the scenarios need
  initial begin
    #320_000;
    failures++;
    report_and_stop();
  end
  initial begin
    {rst, pins, fl, fd, compares, failures} = '0;
    rst = 1'b1;
    code = 4'h1;
    seed = 8'h50;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    `CHK("oe idle", 1'b1, sda_oe_n)
    `CHK("busy idle", 1'b0, busy)
    ctrl(4'h2, inp_pkg::BLK_REG, 1'b0, 1'b0);
    i_mst.stop();
    ctrl(4'h1, 3'h1, 1'b0, 1'b0);
    i_mst.stop();
    repeat (16) begin
      seed = lfsr(seed);
      q.push_back(seed);
    end
    wr(inp_pkg::BLK_NVM, 8'h20, q);
    `CHK("busy prog", 1'b1, busy)
    wr(inp_pkg::BLK_REG, 8'h10, {seed});
    rd(inp_pkg::BLK_REG, 8'h10, 1);
    `CHK("reg in prog", seed, r[0])
    ctrl(code, inp_pkg::BLK_EEP, 1'b0, 1'b0); // polling refused while busy
    i_mst.stop();
    wait_idle();
    rd(inp_pkg::BLK_NVM, 8'h20, 16);
    foreach (q[i]) `CHK("page byte", q[i], r[i])
    ev = {inp_pkg::ERASE_EN_GO, 1'b0, 4'h2};
    wr(inp_pkg::BLK_REG, inp_pkg::ERASE_REG, {ev});
    `CHK("busy erase", 1'b1, busy)
    wait_idle();
    rd(inp_pkg::BLK_NVM, 8'h20, 16);
    foreach (q[i]) `CHK("erased", inp_pkg::ERASED_BYTE, r[i])
    rd(inp_pkg::BLK_REG, inp_pkg::ERASE_REG, 1);
    `CHK("erase en", inp_pkg::ERASE_EN_OFF, r[0][7:5])
    @(posedge mclk);
    pins <= seed[3:0] | 4'h8;
    wr(inp_pkg::BLK_REG, inp_pkg::CTRL_CODE_BYTE, {8'hf1});
    code = pins;
    ctrl(code, inp_pkg::BLK_REG, 1'b0, 1'b1);
    i_mst.stop();
    ctrl(4'h1, inp_pkg::BLK_REG, 1'b0, 1'b0);
    i_mst.stop();
    @(posedge mclk);
    wr(inp_pkg::BLK_EEP, 8'h58, q); // starts mid page, wraps inside page 5
    `CHK("busy eep", 1'b1, busy)
    wait_idle();
    rd(inp_pkg::BLK_EEP, 8'h50, 16);
    foreach (q[i]) `CHK("eep byte", q[i ^ 8], r[i])
    @(posedge mclk);
    fl <= 1'b1;
    fd <= 1'b1;
    wr(inp_pkg::BLK_REG, inp_pkg::ERASE_REG, {ev});
    wait_idle();
    rd(inp_pkg::BLK_EEP, 8'h50, 1);
    `CHK("full blocked", q[8], r[0])
    @(posedge mclk);
    fd <= 1'b0;
    wr(inp_pkg::BLK_REG, inp_pkg::ERASE_REG, {ev});
    wait_idle();
    rd(inp_pkg::BLK_EEP, 8'h50, 16);
    foreach (q[i]) `CHK("full eep", inp_pkg::ERASED_BYTE, r[i])
    rd(inp_pkg::BLK_NVM, 8'h00, 1);
    `CHK("full nvm", inp_pkg::ERASED_BYTE, r[0])
    report_and_stop();
  end
endmodule : i2c_nvm_program_port_tb_top
